// >>> acs_sequencer.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - track phase then conversion phase
// - hold channel for transfer time after start
// - tracking lasts at least fifteen converter periods
// - next tracking overlaps current conversion
// - long tracking extends past previous conversion
// - divider one gives half, 255 gives 1/256
// - conversion lasts twenty-three converter periods
// - averaging multiplies conversion by oversampling ratio
// - free-running mode converts back to back
module acs_sequencer #(
  parameter int TRACK_W = 8,
  parameter int OSR_W   = 4
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             conv_clk_out,
  output logic             gain_amp0_enable_out,
  output logic             gain_amp1_enable_out,
  output logic             conv_start_out,
  output logic             tracking_out,
  output logic      [3:0]  channel_out
);
  // refuse widths that the track counter and the mode fields cannot serve
  if (TRACK_W < 8 || OSR_W < 1 || OSR_W > 4) begin : g_bad_params
    $error("acs_sequencer: bad parameters");
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [1:0]  acr_q;
  logic [31:0] mode_q;
  logic [31:0] timing_q;
  logic        start_req_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  acs_tick_if tk ();
  acs_clk_divider u_div (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .tk       (tk)
  );

  // decode
  wire access     = psel_in & penable_in & ~pready_q;
  wire wr         = access & pwrite_in;
  wire hit_acr    = (paddr_in == acs_pkg::OFF_ANALOG_CONTROL);
  wire hit_mode   = (paddr_in == acs_pkg::OFF_MODE);
  wire hit_start  = (paddr_in == acs_pkg::OFF_START);
  wire hit_status = (paddr_in == acs_pkg::OFF_STATUS);
  wire hit_timing = (paddr_in == acs_pkg::OFF_TIMING);
  wire mapped     = hit_acr | hit_mode | hit_start | hit_status | hit_timing;

  // fields
  wire             freerun   = mode_q[acs_pkg::MR_FREERUN_BIT];
  wire             avg_en    = mode_q[acs_pkg::MR_AVG_BIT];
  wire [OSR_W-1:0] oversampling_ratio       = mode_q[acs_pkg::MR_OSR_LSB +: OSR_W];
  wire [3:0]       ch_first  = mode_q[acs_pkg::MR_CH_LSB +: 4];
  wire [7:0]       track_cfg = timing_q[acs_pkg::TIM_TRACK_LSB +: 8];
  wire [7:0]       xfer_cfg  = timing_q[acs_pkg::TIM_XFER_LSB +: 8];
  wire             amps_on   = acr_q[0] & acr_q[1];
  assign tk.divider = mode_q[acs_pkg::MR_DIV_LSB +: 8];

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  acs_pkg::acs_state_t state_q;
  acs_pkg::acs_state_t state_d;
  logic [15:0]        conv_cnt_q;
  logic [TRACK_W-1:0] track_cnt_q;
  logic [7:0]         xfer_cnt_q;
  logic               conv_busy_q;
  logic [3:0]         chan_q;
  logic               start_q;
  logic               tracking_q;
  logic               pending_q;

  function automatic logic [7:0] at_least(input logic [7:0] v, input logic [7:0] lo);
    at_least = (v < lo) ? lo : v;
  endfunction

  // conversion length in converter periods
  wire [15:0] conv_len = avg_en ?
      16'(acs_pkg::CONV_CYCLES) * 16'(oversampling_ratio == '0 ? 1 : oversampling_ratio)
    : 16'(acs_pkg::CONV_CYCLES);
  wire [7:0]  track_len = at_least(track_cfg, 8'(acs_pkg::TRACK_MIN));
  wire [7:0]  xfer_len  = at_least(xfer_cfg, 8'h01);
  wire        track_done = (track_cnt_q >= TRACK_W'(track_len));
  // previous conversion over, or ending on this tick so free run stays back to back
  wire        prev_done  = ~conv_busy_q |
                           (tk.tick & (conv_cnt_q + 16'h0001 >= conv_len));
  wire        want_conv  = pending_q | freerun;
  wire        can_start  = track_done & prev_done & amps_on;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      acs_pkg::ACS_IDLE:  if (want_conv && amps_on) state_d = acs_pkg::ACS_TRACK;
      acs_pkg::ACS_TRACK: if (tk.tick && can_start) state_d = acs_pkg::ACS_CONV;
      acs_pkg::ACS_CONV:  state_d = acs_pkg::ACS_WAIT;
      acs_pkg::ACS_WAIT:  if (tk.tick && xfer_cnt_q + 8'h01 >= xfer_len)
                            state_d = want_conv ? acs_pkg::ACS_TRACK : acs_pkg::ACS_IDLE;
      default:            state_d = acs_pkg::ACS_IDLE;
    endcase
  end

  // state, counters and channel
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q     <= acs_pkg::ACS_IDLE;
      track_cnt_q <= '0;
      xfer_cnt_q  <= 8'h00;
      chan_q      <= 4'h0;
      start_q     <= 1'b0;
      tracking_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      start_q    <= (state_d == acs_pkg::ACS_CONV);
      tracking_q <= (state_d == acs_pkg::ACS_TRACK);
      if (state_q != acs_pkg::ACS_TRACK)
        track_cnt_q <= '0;
      else if (tk.tick && !track_done)
        track_cnt_q <= track_cnt_q + TRACK_W'(1);
      if (state_q != acs_pkg::ACS_WAIT)
        xfer_cnt_q <= 8'h00;
      else if (tk.tick)
        xfer_cnt_q <= xfer_cnt_q + 8'h01;
      // channel loads ch_first in idle, otherwise changes only when transfer time ends
      if (state_q == acs_pkg::ACS_IDLE)
        chan_q <= ch_first;
      else if (state_q == acs_pkg::ACS_WAIT && state_d == acs_pkg::ACS_TRACK)
        chan_q <= chan_q + 4'h1;
    end
  end

  // conversion in flight, runs during next tracking
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      conv_busy_q <= 1'b0;
      conv_cnt_q  <= 16'h0000;
    end else if (state_q == acs_pkg::ACS_CONV) begin
      conv_busy_q <= 1'b1;
      conv_cnt_q  <= 16'h0000;
    end else if (conv_busy_q && tk.tick) begin
      conv_cnt_q  <= conv_cnt_q + 16'h0001;
      conv_busy_q <= (conv_cnt_q + 16'h0001 < conv_len);
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  wire [31:0] status_word = {16'h0000, 4'(chan_q), 4'h0,
                             2'b00, pending_q, amps_on,
                             conv_busy_q, tracking_q, state_q == acs_pkg::ACS_WAIT,
                             state_q == acs_pkg::ACS_IDLE};
  wire [31:0] rd_mux = hit_acr    ? {30'h0, acr_q} :
                       hit_mode   ? mode_q :
                       hit_status ? status_word :
                       hit_timing ? timing_q : acs_pkg::UNMAPPED_DATA;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      acr_q     <= 2'b00;
      mode_q    <= acs_pkg::MODE_RESET;
      timing_q  <= acs_pkg::TIMING_RESET;
      pending_q <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (access && !pwrite_in) prdata_q <= rd_mux;
      if (wr && hit_acr) acr_q <= {pwdata_in[acs_pkg::ACR_GAIN1_BIT],
                                   pwdata_in[acs_pkg::ACR_GAIN0_BIT]};
      if (wr && hit_mode)   mode_q   <= pwdata_in;
      if (wr && hit_timing) timing_q <= pwdata_in;
      // start request: set wins over the clear taken by the sequencer
      if (wr && hit_start && pwdata_in[0])
        pending_q <= 1'b1;
      else if (state_q == acs_pkg::ACS_CONV)
        pending_q <= 1'b0;
    end
  end

  // outputs straight from flops
  assign prdata_out           = prdata_q;
  assign pready_out           = pready_q;
  assign pslverr_out          = pslverr_q;
  assign conv_clk_out         = tk.conv_clk;
  assign gain_amp0_enable_out = acr_q[0];
  assign gain_amp1_enable_out = acr_q[1];
  assign conv_start_out       = start_q;
  assign tracking_out         = tracking_q;
  assign channel_out          = chan_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_start;
    state_q == acs_pkg::ACS_CONV;
  endsequence

  start_amps_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |-> amps_on) else $error("start with gain amp disabled");
  track_min_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |-> track_cnt_q >= TRACK_W'(acs_pkg::TRACK_MIN))
    else $error("tracking shorter than minimum");
  prev_conv_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |-> !conv_busy_q) else $error("start while previous conversion runs");
  chan_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |=> $stable(chan_q)) else $error("channel changed right after start");
  busy_set_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |=> conv_busy_q && conv_cnt_q == 16'h0000) else $error("conversion not begun");
  phase_order_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_start |-> $past(state_q) == acs_pkg::ACS_TRACK) else $error("start without tracking");
  conv_len_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(conv_busy_q) |-> $past(conv_cnt_q) + 16'h0001 >= conv_len)
    else $error("conversion ended early");
  pulse_one_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    conv_start_out |=> !conv_start_out) else $error("start pulse too long");

  // ---------------------------------------------------------------
  // phase spacing checks
  // ---------------------------------------------------------------
  logic [15:0] since_start_q;

  // helper: converter periods since the last start, saturating
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      since_start_q <= 16'h7fff;
    end else if (state_q == acs_pkg::ACS_CONV) begin
      since_start_q <= 16'h0000;
    end else if (tk.tick && since_start_q != 16'h7fff) begin
      since_start_q <= since_start_q + 16'h0001;
    end
  end

  // transfer time over, channel moves on
  sequence s_wait_done;
    state_q == acs_pkg::ACS_WAIT && state_d == acs_pkg::ACS_TRACK;
  endsequence

  // tracking over, converter about to start
  sequence s_track_done;
    state_q == acs_pkg::ACS_TRACK && state_d == acs_pkg::ACS_CONV;
  endsequence

  // no start before the previous conversion has run its length
  conv_gap_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_track_done |-> since_start_q + 16'h0001 >= conv_len)
    else $error("start before previous conversion ended");

  // channel held for the whole transfer time
  chan_xfer_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_wait_done |-> since_start_q + 16'h0001 >= 16'(xfer_len))
    else $error("channel switched inside transfer time");

  // new channel and tracking begin together
  chan_step_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_wait_done |=> tracking_q && chan_q == $past(chan_q) + 4'h1)
    else $error("tracking without channel change");

  // next tracking runs while the conversion is still busy
  track_overlap_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_wait_done ##0 (since_start_q + 16'h0001 < conv_len) |=> tracking_q && conv_busy_q)
    else $error("tracking does not overlap conversion");

  // conversion never cut short before its length
  conv_full_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    conv_busy_q && tk.tick && conv_cnt_q + 16'h0001 < conv_len |=> conv_busy_q)
    else $error("conversion cut short");

  // nothing leaves idle while an amplifier is off
  idle_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    state_q == acs_pkg::ACS_IDLE && !amps_on |=> state_q == acs_pkg::ACS_IDLE)
    else $error("sequence left idle with amplifier off");

  // a start request waits while an amplifier is off
  pend_keep_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    pending_q && !amps_on |=> pending_q) else $error("start request lost");

  // free run leaves idle at once
  freerun_go_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    freerun && amps_on && state_q == acs_pkg::ACS_IDLE |=> state_q == acs_pkg::ACS_TRACK)
    else $error("free run did not begin tracking");
endmodule
`default_nettype wire

// >>> acs_pkg.sv
`default_nettype none
package acs_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_ANALOG_CONTROL = 12'h000;
  localparam logic [11:0] OFF_MODE           = 12'h004;
  localparam logic [11:0] OFF_START          = 12'h008;
  localparam logic [11:0] OFF_STATUS         = 12'h00c;
  localparam logic [11:0] OFF_TIMING         = 12'h010;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ACR_GAIN0_BIT    = 0;
  localparam int ACR_GAIN1_BIT    = 1;
  localparam int MR_DIV_LSB       = 8;
  localparam int MR_FREERUN_BIT   = 0;
  localparam int MR_AVG_BIT       = 1;
  localparam int MR_OSR_LSB       = 4;
  localparam int MR_CH_LSB        = 16;
  localparam int TIM_TRACK_LSB    = 0;
  localparam int TIM_XFER_LSB     = 8;

  // ---------------------------------------------------------------
  // reset values and timing counts (converter clock periods)
  // ---------------------------------------------------------------
  localparam logic [31:0] MODE_RESET   = 32'h0000_0100;
  localparam logic [31:0] TIMING_RESET = 32'h0000_020f;
  localparam int          CONV_CYCLES  = 23;
  localparam int          TRACK_MIN    = 15;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ACS_IDLE  = 4'b0001,
    ACS_TRACK = 4'b0010,
    ACS_CONV  = 4'b0100,
    ACS_WAIT  = 4'b1000
  } acs_state_t;
endpackage
`default_nettype wire

// >>> acs_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// converter clock tick shared between the divider and the sequencer
interface acs_tick_if;
  logic [7:0] divider;
  logic       tick;
  logic       conv_clk;
  modport src (input divider, output tick, output conv_clk);
  modport dst (output divider, input tick, input conv_clk);
endinterface
`default_nettype wire

// >>> acs_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// converter clock divider: divides by divider+1, and by 2 when divider is 0
// ---------------------------------------------------------------
module acs_clk_divider (
  input  wire logic  mclk_in,
  input  wire logic  reset_in,
  acs_tick_if.src    tk
);
  logic [7:0] cnt_q;
  logic       clk_q;
  logic       wrap;
  logic [7:0] eff_div;

  // value 0 treated as 1 so the clock never stops
  assign eff_div = (tk.divider == 8'h00) ? 8'h01 : tk.divider;
  assign wrap    = (cnt_q >= eff_div);
  assign tk.tick     = wrap;
  assign tk.conv_clk = clk_q;

  // count peripheral clocks, wrap once per converter period
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_q <= 8'h00;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      clk_q <= (cnt_q <= {1'b0, eff_div[7:1]});                // high half, also at divide by 2
    end
  end

  wrap_period_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    wrap |=> !wrap) else $error("tick repeated on back to back cycles");
endmodule
`default_nettype wire

// >>> acs_front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// far side stand-in: converter that tracks its own busy window
// ---------------------------------------------------------------
module acs_front_end_model (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       conv_clk_in,
  input  wire logic       conv_start_in,
  input  wire logic       gain0_in,
  input  wire logic       gain1_in,
  output logic      [7:0] early_start_out,
  output logic            busy_out
);
  logic       clk_prev_q;
  logic [5:0] left_q;
  // counts starts with an amplifier off, and converter periods left
  always @(posedge mclk_in) begin
    if (reset_in) begin
      early_start_out <= 8'h00;
      left_q          <= 6'h00;
      clk_prev_q      <= 1'b0;
    end else begin
      clk_prev_q <= conv_clk_in;
      if (conv_start_in && !(gain0_in && gain1_in))
        early_start_out <= early_start_out + 8'h01;
      if (conv_start_in)
        left_q <= 6'h17;
      else if (conv_clk_in && !clk_prev_q && left_q != 6'h00)
        left_q <= left_q - 6'h01;
    end
  end
  // a conversion is in flight until its periods run out
  assign busy_out = (left_q != 6'h00);
endmodule
`default_nettype wire

// >>> tb_afe_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_afe_conversion_sequencer;
  logic        mclk_in, reset_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, conv_clk_out, conv_start_out, tracking_out, er;
  logic        gain_amp0_enable_out, gain_amp1_enable_out, busy;
  logic [3:0]  channel_out;
  logic [7:0]  early_start;
  logic        clk_prev = 1'b0;
  int          bad_count = 0, num_checks = 0, cyc = 0, last_rise = 0, clk_period = 0;
  int          last_start = 0, start_gap = 0, n_starts = 0, track_len = 0, track_at_start = 0;

  acs_sequencer uut (.mclk_in(mclk_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .conv_clk_out(conv_clk_out),
    .gain_amp0_enable_out(gain_amp0_enable_out), .gain_amp1_enable_out(gain_amp1_enable_out),
    .conv_start_out(conv_start_out), .tracking_out(tracking_out), .channel_out(channel_out));
  acs_front_end_model far_side (.mclk_in(mclk_in), .reset_in(reset_in),
    .conv_clk_in(conv_clk_out), .conv_start_in(conv_start_out), .gain0_in(gain_amp0_enable_out),
    .gain1_in(gain_amp1_enable_out), .early_start_out(early_start), .busy_out(busy));

  // ---------------------------------------------------------------
  // clock and timing monitors
  // ---------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // measures converter clock period, start spacing and tracking length
  always @(posedge mclk_in) begin
    cyc      <= cyc + 1;
    clk_prev <= conv_clk_out;
    track_len <= tracking_out ? track_len + 1 : 0;
    if (conv_clk_out && !clk_prev) begin
      clk_period <= cyc - last_rise;
      last_rise  <= cyc;
    end
    if (conv_start_out) begin
      start_gap      <= cyc - last_start;
      last_start     <= cyc;
      n_starts       <= n_starts + 1;
      track_at_start <= track_len;
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      $display("Error at %0t: no ready on bus", $time);
      bad_count++;
      final_report();
    end
  endtask
  task automatic wait_starts(input int k);
    int n0, n;
    n0 = n_starts;
    n = 0;
    while (n_starts < n0 + k && n < 5000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 5000) begin
      $display("Error at %0t: converter start missing", $time);
      bad_count++;
      final_report();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int dv;
    logic [31:0] mode;
    reset_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0;
    paddr_in = 12'h000; pwdata_in = 32'h0000_0000;
    repeat (6) @(posedge mclk_in);
    reset_in <= 1'b0;
    apb(1'b0, acs_pkg::OFF_MODE, 32'h0);
    check_word(rd, acs_pkg::MODE_RESET);
    apb(1'b0, acs_pkg::OFF_TIMING, 32'h0);
    check_word(rd, acs_pkg::TIMING_RESET);
    apb(1'b0, 12'h020, 32'h0); // unmapped place answers zero with an error
    check_word({rd[30:0], er}, 32'h0000_0001);
    // divider endpoints and a middle value
    for (int i = 0; i < 3; i++) begin
      dv = (i == 0) ? 1 : (i == 1) ? 3 : 255;
      apb(1'b1, acs_pkg::OFF_MODE, 32'(dv) << acs_pkg::MR_DIV_LSB);
      repeat (4 * dv + 8) @(posedge mclk_in);
      check_word(32'(clk_period), 32'(dv + 1));
    end
    // start held back until both amplifiers are on
    mode = (32'h1 << acs_pkg::MR_DIV_LSB) | (32'h3 << acs_pkg::MR_CH_LSB);
    apb(1'b1, acs_pkg::OFF_MODE, mode);
    apb(1'b1, acs_pkg::OFF_START, 32'h1);
    repeat (100) @(posedge mclk_in);
    check_word(32'(n_starts), 32'h0);
    apb(1'b1, acs_pkg::OFF_ANALOG_CONTROL, 32'h3);
    check_word({30'h0, gain_amp1_enable_out, gain_amp0_enable_out}, 32'h3);
    wait_starts(1);
    check_word({31'h0, track_at_start >= 30}, 32'h1);
    check_word({31'h0, tracking_out}, 32'h0);
    check_word({28'h0, channel_out}, 32'h3);
    repeat (2) @(posedge mclk_in);
    check_word({28'h0, channel_out}, 32'h3);
    repeat (8) @(posedge mclk_in);
    check_word({28'h0, channel_out}, 32'h3);
    // free running: back to back, tracking overlaps conversion
    apb(1'b1, acs_pkg::OFF_MODE, mode | 32'h1);
    apb(1'b1, acs_pkg::OFF_START, 32'h1);
    wait_starts(3);
    check_word(32'(start_gap), 32'(46));
    repeat (8) @(posedge mclk_in);
    check_word({30'h0, tracking_out, busy}, 32'h3);
    check_word({28'h0, channel_out}, 32'h6);
    // averaging with a ratio of two doubles the spacing
    apb(1'b1, acs_pkg::OFF_MODE, mode | 32'h23);
    wait_starts(3);
    check_word(32'(start_gap), 32'(92));
    apb(1'b1, acs_pkg::OFF_MODE, mode);
    check_word({24'h0, early_start}, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
